/* hdl/register_file_page_window.sv */
// Address mapper for the paged register file: page pointer, bank select,
// working slice pointers, and the direct/indirect split of the upper area.
// Assumes the core presents one operand address per cycle with its mode.
//
// Contract
// - Page pointer register at DFh, bank 0
// - Reset clears page pointer to page 0
// - Bits 7..4 pick destination page 0-4
// - Bits 3..0 pick source page 0-4
// - C0h-FFh direct accesses hit control set
// - E0h-FFh split into two selectable banks
// - Reset selects bank zero
// - D0h-DFh system, C0h-CFh common scratch
// - Direct control access ignores page pointer
// - Indirect/indexed upper accesses hit duplicate set
// - Duplicate set exists on pages 0-3
// - Prime area paged, all modes allowed
// - Two slice pointers at D6h and D7h
// - Reset pointers select C0h and C8h slices
// - Pointer supplies upper five address bits
// - Working access never reaches duplicate set
// - Pointers loaded by set-pointer or load
// - Operand msb picks pointer, low three bits
// - Upper nibble 1100b means working register
// - Register pairs start even, msb first
`timescale 1ns/1ps
module register_file_page_window
	import regmap_pkg::*;
(
	input  wire logic                    SYS_CLK,
	input  wire logic                    RESET_N,
	input  wire logic                    CLK_EN,
	input  wire regmap_pkg::addr_mode_e  ADDR_MODE,
	input  wire logic [7:0]              OPERAND,
	input  wire logic                    PAIR_ACCESS,
	input  wire logic                    WRITE_CYCLE,
	input  wire logic                    REG_WRITE,
	input  wire logic [7:0]              REG_WDATA,
	input  wire logic                    SELECT_LOW_BANK_INSTR,
	input  wire logic                    SELECT_HIGH_BANK_INSTR,
	input  wire logic                    SET_SLICE_POINTER_INSTR,
	input  wire logic [1:0]              SET_SLICE_WHICH,
	input  wire logic [7:0]              SET_SLICE_VALUE,
	output logic      [7:0]              PHYS_ADDR,
	output logic      [3:0]              PHYS_PAGE,
	output regmap_pkg::area_e            PHYS_AREA,
	output logic                         ADDR_FAULT,
	output logic                         HIT_MAPPED,
	output logic      [7:0]              MAPPED_RDATA,
	output logic      [7:0]              PAGE_SELECT_POINTER,
	output logic      [7:0]              WORKING_SLICE_POINTER_FIRST,
	output logic      [7:0]              WORKING_SLICE_POINTER_SECOND,
	output logic                         BANK_SELECT
);
	import regmap_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	logic [7:0] page_ptr_q;
	logic [7:0] page_ptr_d;
	logic [7:0] slice_first_q;
	logic [7:0] slice_first_d;
	logic [7:0] slice_second_q;
	logic [7:0] slice_second_d;
	logic       bank_q;
	logic       bank_d;

	// ************************************************************
	// Decode nets
	// ************************************************************
	logic       is_work8;
	logic       is_work;
	logic [7:0] raw;
	logic [7:0] addr;
	logic       pair_odd;
	logic       upper;
	logic       ind_mode;
	logic       to_dup;
	logic       to_ctrl;
	logic [3:0] dst_pg;
	logic [3:0] src_pg;
	logic [3:0] use_pg;
	logic       dup_ok;
	logic       common_dir;
	logic       in_bank;
	logic       in_system;
	area_e      area_d;

	// ************************************************************
	// Write and select nets
	// ************************************************************
	logic       wr_pp;
	logic       wr_s0;
	logic       wr_s1;
	logic       srp0;
	logic       srp1;
	logic       srp_both;
	logic [4:0] srp1_slice;
	logic [7:0] srp1_val;

	// ************************************************************
	// Read-back and fault nets
	// ************************************************************
	logic       pp_hit;
	logic       s0_hit;
	logic       s1_hit;
	logic       bad_pg;
	logic       dup_fault;

	// ************************************************************
	// Helper functions
	// ************************************************************
	function automatic logic [7:0] work_addr(input logic [3:0] idx,
		input logic [7:0] p0, input logic [7:0] p1);
		logic [7:0] p;
		p = idx[3] ? p1 : p0;
		work_addr = {p[7:3], idx[2:0]};
	endfunction

	function automatic logic page_legal(input logic [3:0] pg);
		page_legal = (pg <= PAGE_LAST);
	endfunction

	// ************************************************************
	// Operand decoding
	// ************************************************************
	// Eight-bit direct operands with the working prefix never reach C0h-CFh directly
	assign is_work8 = (ADDR_MODE == MODE_DIRECT) && (OPERAND[7:4] == WORK_PREFIX);
	assign is_work  = (ADDR_MODE == MODE_WORK4) || is_work8;

	assign raw = is_work ? work_addr(OPERAND[3:0], slice_first_q, slice_second_q)
	                     : OPERAND;

	// Pairs always address the even byte first; the odd byte follows
	assign addr     = PAIR_ACCESS ? {raw[7:1], 1'b0} : raw;
	assign pair_odd = PAIR_ACCESS && raw[0];

	assign upper    = (addr[7:6] == CTRL_TOP);
	assign ind_mode = (ADDR_MODE == MODE_INDIRECT) || (ADDR_MODE == MODE_INDEXED);

	// Working accesses behave like direct ones in the upper area
	assign to_dup   = upper && ind_mode && !is_work;
	assign to_ctrl  = upper && !to_dup;

	// ************************************************************
	// Page selection
	// ************************************************************
	assign dst_pg = page_ptr_q[DEST_MSB:DEST_LSB];
	assign src_pg = page_ptr_q[SRC_MSB:SRC_LSB];

	// Reads take the source page, result writes the destination page
	assign use_pg = WRITE_CYCLE ? dst_pg : src_pg;

	// Page 4 carries no duplicate upper set
	assign dup_ok = (use_pg <= DUP_PAGE_LAST);

	// Direct C0h-CFh is not a legal route to the common area
	assign common_dir = to_ctrl && !is_work && (addr[7:4] == COMMON_NIBBLE);

	// ************************************************************
	// Area selection
	// ************************************************************
	assign in_bank   = (addr[7:5] == BANK_TOP);
	assign in_system = (addr[7:4] == SYS_NIBBLE);

	always_comb begin
		if (!upper) begin
			area_d = AREA_PRIME;
		end else if (to_dup) begin
			area_d = dup_ok ? AREA_DUPLICATE : AREA_NONE;
		end else if (in_bank) begin
			area_d = bank_q ? AREA_CONTROL_BANK_ONE : AREA_CONTROL_BANK_ZERO;
		end else if (in_system) begin
			area_d = AREA_SYSTEM;
		end else begin
			area_d = AREA_COMMON;
		end
	end

	// ************************************************************
	// Register write decode
	// ************************************************************
	// Only control-set routes reach the pointers; duplicate hits leave them alone
	assign wr_pp = REG_WRITE && to_ctrl && in_system && (addr == PAGE_PTR_ADDR);
	assign wr_s0 = REG_WRITE && to_ctrl && (addr == SLICE_FIRST_ADDR);
	assign wr_s1 = REG_WRITE && to_ctrl && (addr == SLICE_SECOND_ADDR);

	assign srp0     = SET_SLICE_POINTER_INSTR && SET_SLICE_WHICH[0];
	assign srp1     = SET_SLICE_POINTER_INSTR && SET_SLICE_WHICH[1];
	assign srp_both = (SET_SLICE_WHICH == 2'b11);

	// A both-pointer set places the second slice right above the first;
	// the slice number wraps at the top of the file on purpose
	assign srp1_slice = 5'(SET_SLICE_VALUE[7:3] + 5'h01);
	assign srp1_val   = srp_both ? {srp1_slice, 3'b000} : SET_SLICE_VALUE;

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		page_ptr_d = page_ptr_q;
		if (wr_pp) begin
			page_ptr_d = REG_WDATA;
		end
	end

	// Set-pointer wins over an ordinary load in the same cycle
	always_comb begin
		slice_first_d = slice_first_q;
		if (srp0) begin
			slice_first_d = SET_SLICE_VALUE;
		end else if (wr_s0) begin
			slice_first_d = REG_WDATA;
		end
	end

	always_comb begin
		slice_second_d = slice_second_q;
		if (srp1) begin
			slice_second_d = srp1_val;
		end else if (wr_s1) begin
			slice_second_d = REG_WDATA;
		end
	end

	// High bank wins if both bank instructions arrive together
	always_comb begin
		bank_d = bank_q;
		if (SELECT_HIGH_BANK_INSTR) begin
			bank_d = 1'b1;
		end else if (SELECT_LOW_BANK_INSTR) begin
			bank_d = 1'b0;
		end
	end

	// ************************************************************
	// Pointer and bank select registers
	// ************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			page_ptr_q     <= PAGE_PTR_RESET;
			slice_first_q  <= SLICE_FIRST_RESET;
			slice_second_q <= SLICE_SECOND_RESET;
			bank_q         <= 1'b0;
		end else if (CLK_EN) begin
			page_ptr_q     <= page_ptr_d;
			slice_first_q  <= slice_first_d;
			slice_second_q <= slice_second_d;
			bank_q         <= bank_d;
		end
	end

	// ************************************************************
	// Read-back decode
	// ************************************************************
	assign pp_hit = to_ctrl && (addr == PAGE_PTR_ADDR);
	assign s0_hit = to_ctrl && (addr == SLICE_FIRST_ADDR);
	assign s1_hit = to_ctrl && (addr == SLICE_SECOND_ADDR);

	// ************************************************************
	// Fault decode
	// ************************************************************
	// Control-set hits ignore the page pointer, so a reserved page cannot fault them
	assign bad_pg    = !page_legal(use_pg) && !to_ctrl;
	assign dup_fault = to_dup && (area_d == AREA_NONE);

	// ************************************************************
	// Outputs
	// ************************************************************
	// The odd half of a pair is flagged, never emitted as an address
	assign PHYS_ADDR    = addr;
	assign PHYS_PAGE    = to_ctrl ? 4'h0 : use_pg;
	assign PHYS_AREA    = bad_pg ? AREA_NONE : area_d;
	assign ADDR_FAULT   = bad_pg || dup_fault || common_dir || pair_odd;
	assign HIT_MAPPED   = pp_hit || s0_hit || s1_hit;
	assign MAPPED_RDATA = pp_hit ? page_ptr_q :
	                      s0_hit ? slice_first_q :
	                      s1_hit ? slice_second_q : 8'h00;

	assign PAGE_SELECT_POINTER          = page_ptr_q;
	assign WORKING_SLICE_POINTER_FIRST  = slice_first_q;
	assign WORKING_SLICE_POINTER_SECOND = slice_second_q;
	assign BANK_SELECT                  = bank_q;

endmodule

/* hdl/regmap_pkg.sv */
// Package of constants for the paged register file address mapper.
// Assumes an 8-bit register address from the core operand address generator.
package regmap_pkg;
	localparam logic [7:0] PAGE_PTR_ADDR     = 8'hdf;
	localparam logic [7:0] SLICE_FIRST_ADDR  = 8'hd6;
	localparam logic [7:0] SLICE_SECOND_ADDR = 8'hd7;
	localparam logic [7:0] PAGE_PTR_RESET    = 8'h00;
	localparam logic [7:0] SLICE_FIRST_RESET = 8'hc0;
	localparam logic [7:0] SLICE_SECOND_RESET = 8'hc8;
	localparam logic [3:0] WORK_PREFIX       = 4'hc;
	localparam int         DEST_MSB          = 7;
	localparam int         DEST_LSB          = 4;
	localparam int         SRC_MSB           = 3;
	localparam int         SRC_LSB           = 0;
	localparam logic [3:0] PAGE_LAST         = 4'h4;
	localparam logic [3:0] DUP_PAGE_LAST     = 4'h3;
	localparam logic [1:0] CTRL_TOP          = 2'b11;
	localparam logic [2:0] BANK_TOP          = 3'b111;
	localparam logic [3:0] SYS_NIBBLE        = 4'hd;
	localparam logic [3:0] COMMON_NIBBLE     = 4'hc;
	// Addressing modes presented by the core
	typedef enum logic [2:0] {
		MODE_DIRECT,
		MODE_WORK4,
		MODE_INDIRECT,
		MODE_INDEXED,
		MODE_OTHER
	} addr_mode_e;
	// Physical regions the mapper resolves to
	typedef enum logic [2:0] {
		AREA_PRIME,
		AREA_COMMON,
		AREA_SYSTEM,
		AREA_CONTROL_BANK_ZERO,
		AREA_CONTROL_BANK_ONE,
		AREA_DUPLICATE,
		AREA_NONE
	} area_e;
endpackage

/* tb/regmap_chk.sv */
// Checker for the page window mapper, bound to its top ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module regmap_chk
	import regmap_pkg::*;
(
	input wire logic                   SYS_CLK,
	input wire logic                   RESET_N,
	input wire logic                   CLK_EN,
	input wire regmap_pkg::addr_mode_e ADDR_MODE,
	input wire logic [7:0]             OPERAND,
	input wire logic                   PAIR_ACCESS,
	input wire logic                   WRITE_CYCLE,
	input wire logic                   REG_WRITE,
	input wire logic [7:0]             REG_WDATA,
	input wire logic                   SELECT_HIGH_BANK_INSTR,
	input wire logic [7:0]             PHYS_ADDR,
	input wire logic [3:0]             PHYS_PAGE,
	input wire regmap_pkg::area_e      PHYS_AREA,
	input wire logic                   ADDR_FAULT,
	input wire logic [7:0]             PAGE_SELECT_POINTER,
	input wire logic [7:0]             WORKING_SLICE_POINTER_FIRST,
	input wire logic [7:0]             WORKING_SLICE_POINTER_SECOND,
	input wire logic                   BANK_SELECT
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	// Page nibble that applies to this access
	wire [3:0] pg = WRITE_CYCLE ? PAGE_SELECT_POINTER[7:4] : PAGE_SELECT_POINTER[3:0];
	wire wk = ADDR_MODE == MODE_WORK4 || (ADDR_MODE == MODE_DIRECT && OPERAND[7:4] == WORK_PREFIX);
	wire ind = ADDR_MODE inside {MODE_INDIRECT, MODE_INDEXED};
	wire up = OPERAND[7:6] == 2'b11;
	wire prm = ADDR_MODE != MODE_OTHER && !wk && !up;
	a_reset_state: assert property ($rose(RESET_N) |-> PAGE_SELECT_POINTER == 8'h00 && !BANK_SELECT
		&& WORKING_SLICE_POINTER_FIRST == 8'hc0 && WORKING_SLICE_POINTER_SECOND == 8'hc8)
		else $error("pointer state after reset wrong");
	a_page_load: assert property (REG_WRITE && CLK_EN && ADDR_MODE == MODE_DIRECT
		&& OPERAND == PAGE_PTR_ADDR |=> PAGE_SELECT_POINTER == $past(REG_WDATA)) else $error("page load");
	a_work_addr: assert property (wk && !PAIR_ACCESS |-> PHYS_AREA != AREA_DUPLICATE && PHYS_ADDR ==
		(OPERAND[3] ? {WORKING_SLICE_POINTER_SECOND[7:3], OPERAND[2:0]}
		: {WORKING_SLICE_POINTER_FIRST[7:3], OPERAND[2:0]})) else $error("working address");
	a_direct_ctrl: assert property (ADDR_MODE == MODE_DIRECT && up && !wk |-> PHYS_PAGE == 4'h0
		&& PHYS_AREA != AREA_DUPLICATE) else $error("direct control access");
	a_dup_route: assert property (ind && up && pg < 4'h4 |-> PHYS_AREA == AREA_DUPLICATE
		&& PHYS_PAGE == pg) else $error("duplicate routing");
	a_dup_page4: assert property (ind && up && pg == 4'h4 |-> ADDR_FAULT) else $error("dup page 4");
	a_prime_page: assert property (prm && pg <= 4'h4 |-> PHYS_PAGE == pg && PHYS_AREA == AREA_PRIME)
		else $error("prime page");
	a_reserved_page: assert property (prm && pg > 4'h4 |-> ADDR_FAULT) else $error("reserved page");
	a_pair_even: assert property (PAIR_ACCESS |-> !PHYS_ADDR[0]) else $error("odd pair address");
	a_bank_set: assert property (SELECT_HIGH_BANK_INSTR && CLK_EN |=> BANK_SELECT) else $error("bank");
	a_bank_area: assert property (ADDR_MODE == MODE_DIRECT && OPERAND[7:5] == BANK_TOP |->
		PHYS_AREA == (BANK_SELECT ? AREA_CONTROL_BANK_ONE : AREA_CONTROL_BANK_ZERO)) else $error("bank area");
	c_dup: cover property (ind && up && pg < 4'h4);
	c_work: cover property (wk);
	c_fault: cover property (ADDR_FAULT);
endmodule

/* tb/regmap_core_model.sv */
// Core-side operand requester; drives every mapper input except SYS_CLK and RESET_N.
// Assumes the mapper takes requests on the rising SYS_CLK edge.
`timescale 1ns/1ps
module regmap_core_model
	import regmap_pkg::*;
(
	input  wire logic              SYS_CLK,
	output regmap_pkg::addr_mode_e ADDR_MODE,
	output logic [7:0]             OPERAND,
	output logic [7:0]             REG_WDATA,
	output logic [7:0]             SET_SLICE_VALUE,
	output logic [1:0]             SET_SLICE_WHICH,
	output logic                   PAIR_ACCESS,
	output logic                   WRITE_CYCLE,
	output logic                   CLK_EN,
	output logic                   SET_SLICE_POINTER_INSTR,
	output logic                   SELECT_HIGH_BANK_INSTR,
	output logic                   SELECT_LOW_BANK_INSTR,
	output logic                   REG_WRITE
);
	// Control bits, msb first: pair, write, hold, set pointer, high bank, low bank, load
	task automatic cyc(input addr_mode_e m, input logic [7:0] o, input logic [6:0] c,
		input logic [7:0] d, input logic [1:0] k);
		@(posedge SYS_CLK);
		ADDR_MODE <= m;
		OPERAND <= o;
		{PAIR_ACCESS, WRITE_CYCLE, SET_SLICE_POINTER_INSTR, SELECT_HIGH_BANK_INSTR,
			SELECT_LOW_BANK_INSTR, REG_WRITE} <= {c[6:5], c[3:0]};
		CLK_EN <= !c[4];
		{REG_WDATA, SET_SLICE_VALUE, SET_SLICE_WHICH} <= {d, d, k};
	endtask
	initial begin
		{ADDR_MODE, OPERAND, REG_WDATA, SET_SLICE_VALUE, SET_SLICE_WHICH} = '0;
		{PAIR_ACCESS, WRITE_CYCLE, SET_SLICE_POINTER_INSTR, SELECT_HIGH_BANK_INSTR} = '0;
		{SELECT_LOW_BANK_INSTR, REG_WRITE, CLK_EN} = 3'b001;
	end
endmodule

/* tb/register_file_page_window_tb_top.sv */
// Self-checking bench for the register file page window mapper.
// Assumes the core model drives every mapper input except SYS_CLK and RESET_N, which the bench drives.
`timescale 1ns/1ps
module register_file_page_window_tb_top;
	import regmap_pkg::*;
	logic SYS_CLK = 1'b0;
	logic RESET_N = 1'b0;
	addr_mode_e ADDR_MODE;
	area_e PHYS_AREA;
	logic CLK_EN, PAIR_ACCESS, WRITE_CYCLE, REG_WRITE, SELECT_LOW_BANK_INSTR, ADDR_FAULT;
	logic SELECT_HIGH_BANK_INSTR, SET_SLICE_POINTER_INSTR, HIT_MAPPED, BANK_SELECT;
	logic [1:0] SET_SLICE_WHICH;
	logic [3:0] PHYS_PAGE;
	logic [7:0] OPERAND, REG_WDATA, SET_SLICE_VALUE, PHYS_ADDR, MAPPED_RDATA;
	logic [7:0] PAGE_SELECT_POINTER, WORKING_SLICE_POINTER_FIRST, WORKING_SLICE_POINTER_SECOND;
	logic [7:0] pp = 8'h00, f = 8'hc0, s = 8'hc8;
	logic [7:0] pp_list [5] = '{8'h21, 8'h43, 8'h40, 8'h05, 8'h50};
	logic [12:0] exp_q [$];
	int miscompares = 0, check_count = 0, cycles = 0, seed = 3;
	regmap_core_model core (.*);
	register_file_page_window dut (.*);
	always #50 SYS_CLK = ~SYS_CLK;
	task automatic chk(input logic [24:0] seen, input logic [24:0] expct, input string what);
		check_count++;
		if (seen !== expct) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, expct, seen);
		end
	endtask
	task automatic final_report();
		if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Page is left out of the note on faulting accesses, where it means nothing
	function automatic logic [12:0] map_note(addr_mode_e m, logic [7:0] o, logic w, logic p);
		logic wk, dp, fl;
		logic [7:0] a;
		logic [3:0] g, pg;
		wk = m == MODE_WORK4 || (m == MODE_DIRECT && o[7:4] == 4'hc);
		a = !wk ? o : o[3] ? {s[7:3], o[2:0]} : {f[7:3], o[2:0]};
		dp = !wk && o[7:6] == 2'b11 && m != MODE_DIRECT;
		g = w ? pp[7:4] : pp[3:0];
		pg = (a[7:6] == 2'b11 && !dp) ? 4'h0 : g;
		fl = pg > 4'h4 || (dp && g == 4'h4) || (p && o[0]);
		return {fl, fl ? 4'h0 : pg, a[7:1], a[0] && !p};
	endfunction
	task automatic burst();
		logic [7:0] r;
		for (int j = 0; j < 32; j++) begin
			r = 8'($random(seed));
			r = (j % 4 == 0 && j[2]) ? {4'hc, r[3:0]} : r;
			core.cyc(addr_mode_e'(j % 4), r, {j % 4 > 1 && r[5], r[4], 5'h00}, 8'h00, 2'b00);
			exp_q.push_back(map_note(addr_mode_e'(j % 4), r, r[4], j % 4 > 1 && r[5]));
		end
	endtask
	always @(negedge SYS_CLK) if (exp_q.size() > 0)
		chk({ADDR_FAULT, ADDR_FAULT ? 4'h0 : PHYS_PAGE, PHYS_ADDR}, exp_q.pop_front(), "map");
	always @(posedge SYS_CLK) if (++cycles == 1000) begin
		miscompares++;
		final_report();
	end
	initial begin
		repeat (6) @(posedge SYS_CLK);
		RESET_N <= 1'b1;
		@(negedge SYS_CLK);
		chk({PAGE_SELECT_POINTER, WORKING_SLICE_POINTER_FIRST, WORKING_SLICE_POINTER_SECOND,
			BANK_SELECT}, {24'h00c0c8, 1'b0}, "reset");
		burst();
		core.cyc(MODE_OTHER, 8'h00, 7'h08, 8'h70, 2'b11);
		{f, s} = 16'h7078;
		burst();
		core.cyc(MODE_OTHER, 8'h00, 7'h08, 8'h48, 2'b10);
		core.cyc(MODE_DIRECT, SLICE_FIRST_ADDR, 7'h01, 8'ha0, 2'b00);
		{f, s} = 16'ha048;
		core.cyc(MODE_DIRECT, SLICE_SECOND_ADDR, 7'h00, 8'h00, 2'b00);
		@(negedge SYS_CLK);
		chk({HIT_MAPPED, MAPPED_RDATA, WORKING_SLICE_POINTER_FIRST}, {1'b1, s, f}, "readback");
		for (int i = 0; i < 5; i++) begin
			pp = pp_list[i];
			core.cyc(MODE_DIRECT, PAGE_PTR_ADDR, 7'h01, pp, 2'b00);
			burst();
		end
		core.cyc(MODE_OTHER, 8'h00, 7'h04, 8'h00, 2'b00);
		core.cyc(MODE_DIRECT, PAGE_PTR_ADDR, 7'h13, 8'hff, 2'b00);
		core.cyc(MODE_OTHER, 8'h00, 7'h02, 8'h00, 2'b00);
		@(negedge SYS_CLK);
		chk({PAGE_SELECT_POINTER, BANK_SELECT}, {pp, 1'b1}, "hold");
		core.cyc(MODE_OTHER, 8'h00, 7'h00, 8'h00, 2'b00);
		@(negedge SYS_CLK);
		chk(BANK_SELECT, 1'b0, "bank");
		final_report();
	end
endmodule
bind register_file_page_window regmap_chk chk (.*);
